/* hw/pin_mode_strap_mux_map.svh */
// Constants for the pin mode strap multiplexer
`ifndef PIN_MODE_STRAP_MUX_MAP_SVH
`define PIN_MODE_STRAP_MUX_MAP_SVH
`define EXT_ADDR_W 14
`define EXT_DATA_W 24
`define HOST_BUS_W 16
`define BYTE_ADDR_HI_W 8
`define HOST_DATA_LSB 8
`define STRAP_W 3
`define STRAP_MODE_C_BIT 2
`define STRAP_RESET_VAL 3'h0
`define MODE_C_HOST 1'b1
`endif

/* hw/pin_mode_strap_mux_pkg.sv */
// Types for the pin mode strap multiplexer
`include "pin_mode_strap_mux_map.svh"
package pin_mode_strap_mux_pkg;
	typedef enum logic {FULL_MEMORY, HOST_MODE} mem_mode_t;
	typedef enum logic [1:0] {ST_RESET, ST_RUN} phase_t;
	typedef struct packed {
		logic [`EXT_ADDR_W-1:0] addr;
		logic [`EXT_DATA_W-1:0] data_out;
		logic [`EXT_DATA_W-1:0] data_oe;
		logic [`BYTE_ADDR_HI_W-1:0] byte_addr_hi;
		logic byte_access;
	} core_bus_t;
	typedef struct packed {
		logic [`HOST_BUS_W-1:0] dout;
		logic [`HOST_BUS_W-1:0] oe;
		logic ack;
	} host_core_t;
	typedef struct packed {
		logic write_strobe;
		logic read_strobe;
		logic address_latch;
		logic port_select;
	} host_ctl_t;
	typedef struct packed {
		logic [`HOST_BUS_W-1:0] addr_data;
		logic write_strobe;
		logic read_strobe;
		logic address_latch;
		logic port_select;
	} host_in_t;
endpackage

/* hw/pin_mode_strap_mux.sv */
// Strap sampling, memory-mode pin muxing and shared flag/interrupt pins
// Summary of operation
// - Mode C strap is sampled in reset and held until the next reset.
// - The three straps are read only in reset and then serve as flag pins.
// - Mode C low selects full-memory mode with byte transfers.
// - Full mode drives 14 address and 24 data bits, top 8 as byte address.
// - Mode C high gives host mode: 16-bit host bus, strobes and acknowledge.
// - Host mode keeps only the low address bit and the upper 16 data bits.
// - Shared interrupt/flag pins keep both roles at once.
// - An unmasked shared pin interrupts whether driven outside or by its flag.
// - A control bit makes serial port two pins two interrupts and two flags.
// - Bus pin roles are fixed in reset; serial pin roles may change any time.
`timescale 1ns/10ps
`default_nettype none
`include "pin_mode_strap_mux_map.svh"
module pin_mode_strap_mux (
	input wire logic mclk,
	input wire logic resetn,
	// Strap / flag pins 2:0
	input wire logic [`STRAP_W-1:0] strap_flag_in,
	output logic [`STRAP_W-1:0] strap_flag_out,
	output logic [`STRAP_W-1:0] strap_flag_oe,
	input wire logic [`STRAP_W-1:0] core_flag_out,
	input wire logic [`STRAP_W-1:0] core_flag_dir,
	output logic [`STRAP_W-1:0] core_flag_in,
	output pin_mode_strap_mux_pkg::mem_mode_t mem_mode,
	output logic [`STRAP_W-1:0] strap_value,
	// Shared interrupt / flag pins 7:4
	input wire logic [3:0] shared_pin_in,
	output logic [3:0] shared_pin_out,
	output logic [3:0] shared_pin_oe,
	input wire logic [3:0] shared_flag_out,
	input wire logic [3:0] shared_flag_dir,
	input wire logic [3:0] interrupt_mask_reg,
	output logic [3:0] shared_flag_in,
	output logic [3:0] shared_irq_req,
	// Core-side bus and host port
	input wire pin_mode_strap_mux_pkg::core_bus_t core_bus,
	input wire pin_mode_strap_mux_pkg::host_core_t host_core,
	output pin_mode_strap_mux_pkg::host_in_t host_in,
	// External bus pins
	output logic [`EXT_ADDR_W-1:0] external_address_bus,
	input wire logic [`EXT_DATA_W-1:0] external_data_bus_in,
	output logic [`EXT_DATA_W-1:0] external_data_bus_out,
	output logic [`EXT_DATA_W-1:0] external_data_bus_oe,
	output logic [`EXT_DATA_W-1:0] core_data_in,
	// Host port pins
	input wire logic [`HOST_BUS_W-1:0] host_addr_data_bus_in,
	output logic [`HOST_BUS_W-1:0] host_addr_data_bus_out,
	output logic [`HOST_BUS_W-1:0] host_addr_data_bus_oe,
	input wire pin_mode_strap_mux_pkg::host_ctl_t host_ctl_pins,
	output logic host_port_acknowledge,
	// Second serial port
	input wire logic serial_alt_mode,
	input wire logic [1:0] serial_irq_edge_sel,
	input wire logic serial_data_in,
	output logic serial_data_out,
	input wire logic serial_core_tx,
	output logic serial_core_rx,
	input wire logic [1:0] serial_clk_fs_in,
	input wire logic alt_flag_output_core,
	output logic alt_flag_input,
	output logic [1:0] alt_serial_irq_pins
);
	import pin_mode_strap_mux_pkg::*;

	// Host mode keeps only the upper data lanes
	function automatic logic [`EXT_DATA_W-1:0] host_data_mask();
		return {{`HOST_BUS_W{1'b1}}, {`HOST_DATA_LSB{1'b0}}};
	endfunction

	phase_t phase_q, phase_d;
	mem_mode_t mode_q, mode_d;
	logic [`STRAP_W-1:0] strap_q, strap_d;
	logic [1:0] irq_prev_q, irq_prev_d;
	logic [1:0] sirq_q, sirq_d;
	logic host;

	// Straps are taken on every clock edge while reset is held, so the
	// clock must run in reset; an outside strap driver lets go at
	// release, and a level read after that would be the flag level.
	always_comb begin
		phase_d = ST_RUN;
		mode_d = mode_q;
		strap_d = strap_q;
		if (!resetn)
			strap_d = strap_flag_in;
		case (phase_q)
		ST_RESET: begin
			mode_d = (strap_q[`STRAP_MODE_C_BIT] == `MODE_C_HOST) ?
				HOST_MODE : FULL_MEMORY;
		end
		ST_RUN: phase_d = ST_RUN;
		default: phase_d = ST_RUN;
		endcase
	end

	// No async reset here: its reset branch would have to load pin data
	always_ff @(posedge mclk) begin
		strap_q <= strap_d;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= ST_RESET;
			mode_q <= FULL_MEMORY;
		end else begin
			phase_q <= phase_d;
			mode_q <= mode_d;
		end
	end

	assign host = (mode_q == HOST_MODE);

	// Serial interrupt sense: edge-selected lines fire on a falling edge
	always_comb begin
		irq_prev_d = serial_clk_fs_in;
		for (int i = 0; i < 2; i++) begin
			if (serial_irq_edge_sel[i])
				sirq_d[i] = irq_prev_q[i] & ~serial_clk_fs_in[i];
			else
				sirq_d[i] = ~serial_clk_fs_in[i];
			if (!serial_alt_mode)
				sirq_d[i] = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_prev_q <= 2'h3;
			sirq_q <= 2'h0;
		end else begin
			irq_prev_q <= irq_prev_d;
			sirq_q <= sirq_d;
		end
	end

	// Registered pin outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strap_flag_out <= 3'h0;
			strap_flag_oe <= 3'h0;
			core_flag_in <= 3'h0;
			mem_mode <= FULL_MEMORY;
			strap_value <= `STRAP_RESET_VAL;
			shared_pin_out <= 4'h0;
			shared_pin_oe <= 4'h0;
			shared_flag_in <= 4'h0;
			shared_irq_req <= 4'h0;
			host_in <= '0;
			external_address_bus <= 14'h0;
			external_data_bus_out <= 24'h0;
			external_data_bus_oe <= 24'h0;
			core_data_in <= 24'h0;
			host_addr_data_bus_out <= 16'h0;
			host_addr_data_bus_oe <= 16'h0;
			host_port_acknowledge <= 1'b0;
			serial_data_out <= 1'b0;
			serial_core_rx <= 1'b0;
			alt_flag_input <= 1'b0;
			alt_serial_irq_pins <= 2'h0;
		end else begin
			// Flag pin drivers stay off until the straps are taken
			strap_flag_out <= core_flag_out;
			strap_flag_oe <= (phase_q == ST_RUN) ?
				core_flag_dir : 3'h0;
			core_flag_in <= strap_flag_in;
			mem_mode <= mode_d;
			strap_value <= strap_d;
			shared_pin_out <= shared_flag_out;
			shared_pin_oe <= (phase_q == ST_RUN) ? shared_flag_dir : 4'h0;
			shared_flag_in <= shared_pin_in;
			// Pin level includes own flag drive, so self-set flags interrupt
			shared_irq_req <= shared_pin_in & interrupt_mask_reg;
			if (host) begin
				external_address_bus <= {13'h0, core_bus.addr[0]};
				external_data_bus_out <= core_bus.data_out & host_data_mask();
				external_data_bus_oe <= core_bus.data_oe & host_data_mask();
				core_data_in <= external_data_bus_in & host_data_mask();
				host_addr_data_bus_out <= host_core.dout;
				host_addr_data_bus_oe <= host_core.oe;
				host_port_acknowledge <= host_core.ack;
				host_in <= {host_addr_data_bus_in, host_ctl_pins};
			end else begin
				external_address_bus <= core_bus.addr;
				external_data_bus_out <= core_bus.byte_access ?
					{core_bus.byte_addr_hi, core_bus.data_out[15:0]} :
					core_bus.data_out;
				external_data_bus_oe <= core_bus.byte_access ?
					{8'hff, core_bus.data_oe[15:0]} : core_bus.data_oe;
				core_data_in <= external_data_bus_in;
				host_addr_data_bus_out <= 16'h0;
				host_addr_data_bus_oe <= 16'h0;
				host_port_acknowledge <= 1'b0;
				host_in <= '0;
			end
			serial_data_out <= serial_alt_mode ?
				alt_flag_output_core : serial_core_tx;
			serial_core_rx <= serial_alt_mode ? 1'b0 : serial_data_in;
			alt_flag_input <= serial_alt_mode & serial_data_in;
			alt_serial_irq_pins <= sirq_q;
		end
	end

	AST_MODE_HELD: assert property (
		@(posedge mclk) disable iff (!resetn)
		phase_q == ST_RUN |=> $stable(mode_q))
		else $error("memory mode changed outside reset");
	AST_STRAP_TAKEN: assert property (
		@(posedge mclk)
		!resetn |=> strap_q == $past(strap_flag_in))
		else $error("strap level not taken in reset");
	AST_MODE_FROM_STRAP: assert property (
		@(posedge mclk) disable iff (!resetn)
		phase_q == ST_RESET |=> (mode_q == HOST_MODE) ==
		$past(strap_q[`STRAP_MODE_C_BIT]))
		else $error("mode does not follow strap");
	AST_STRAP_DRV_OFF: assert property (
		@(posedge mclk) disable iff (!resetn)
		phase_q == ST_RESET |=> strap_flag_oe == 3'h0)
		else $error("strap pin driven before straps taken");
	AST_FLAG_DIR: assert property (
		@(posedge mclk) disable iff (!resetn)
		phase_q == ST_RUN |=> strap_flag_oe == $past(core_flag_dir))
		else $error("strap pin not acting as flag");
	AST_HOST_ADDR: assert property (
		@(posedge mclk) disable iff (!resetn)
		##1 host |=> external_address_bus[13:1] == 13'h0)
		else $error("host mode drives high address bits");
	AST_HOST_LOW_DATA: assert property (
		@(posedge mclk) disable iff (!resetn)
		host |=> external_data_bus_oe[7:0] == 8'h0)
		else $error("host mode drives low data bits");
	AST_FULL_ADDR: assert property (
		@(posedge mclk) disable iff (!resetn)
		!host |=> external_address_bus == $past(core_bus.addr))
		else $error("full-memory address not passed");
	AST_SHARED_IRQ: assert property (
		@(posedge mclk) disable iff (!resetn)
		1'b1 |=> shared_irq_req ==
		($past(shared_pin_in) & $past(interrupt_mask_reg)))
		else $error("shared interrupt request mismatch");
	AST_SERIAL_ALT: assert property (
		@(posedge mclk) disable iff (!resetn)
		!serial_alt_mode ##1 !serial_alt_mode |=> alt_serial_irq_pins == 2'h0)
		else $error("serial interrupts active in normal role");
endmodule
`default_nettype wire

/* sim/strap_driver_model.sv */
// Outside strap driver and wiring of the three strap/flag pins
`timescale 1ns/10ps
`default_nettype none
module strap_driver_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [2:0] mode_val,
	input wire logic [2:0] dut_out,
	input wire logic [2:0] dut_oe,
	output logic [2:0] pin
);
	logic [2:0] last_q;
	logic [2:0] ext;
	// Drives only while reset is low, then floats
	// No pull on the line, so a floated pin shows the inverse, not a stale level
	always_comb begin
		ext = resetn ? ~last_q : mode_val;
		pin = (dut_oe & dut_out) | (~dut_oe & ext);
	end
	always_ff @(posedge mclk) begin
		if (!resetn)
			last_q <= mode_val;
	end
endmodule
`default_nettype wire

/* sim/pin_mode_strap_mux_tb.sv */
// Testbench for the pin mode strap multiplexer
`timescale 1ns/10ps
`default_nettype none
module pin_mode_strap_mux_tb;
	import pin_mode_strap_mux_pkg::*;
	logic mclk, resetn, seen;
	logic [2:0] mode_val, strap_flag_in, strap_flag_out, strap_flag_oe;
	logic [2:0] core_flag_out, core_flag_dir, core_flag_in, strap_value;
	mem_mode_t mem_mode;
	logic [3:0] sh_ext, shared_pin_in, shared_pin_out, shared_pin_oe;
	logic [3:0] shared_flag_out, shared_flag_dir, interrupt_mask_reg;
	logic [3:0] shared_flag_in, shared_irq_req;
	core_bus_t core_bus;
	host_core_t host_core;
	host_in_t host_in;
	host_ctl_t host_ctl_pins;
	logic [13:0] external_address_bus;
	logic [23:0] external_data_bus_in, external_data_bus_out;
	logic [23:0] external_data_bus_oe, core_data_in;
	logic [15:0] host_addr_data_bus_in, host_addr_data_bus_out;
	logic [15:0] host_addr_data_bus_oe;
	logic host_port_acknowledge, serial_alt_mode, serial_data_in;
	logic serial_data_out, serial_core_tx, serial_core_rx;
	logic alt_flag_output_core, alt_flag_input;
	logic [1:0] serial_irq_edge_sel, serial_clk_fs_in, alt_serial_irq_pins;
	int err_count, samples_checked;
	// Flag drive loops back onto the shared pin
	assign shared_pin_in = (shared_pin_oe & shared_pin_out) |
		(~shared_pin_oe & sh_ext);
	strap_driver_model strap_drv (.mclk, .resetn, .mode_val,
		.dut_out(strap_flag_out), .dut_oe(strap_flag_oe), .pin(strap_flag_in));
	pin_mode_strap_mux dut (.mclk, .resetn, .strap_flag_in, .strap_flag_out,
		.strap_flag_oe, .core_flag_out, .core_flag_dir, .core_flag_in,
		.mem_mode, .strap_value, .shared_pin_in, .shared_pin_out,
		.shared_pin_oe, .shared_flag_out, .shared_flag_dir,
		.interrupt_mask_reg, .shared_flag_in, .shared_irq_req, .core_bus,
		.host_core, .host_in, .external_address_bus, .external_data_bus_in,
		.external_data_bus_out, .external_data_bus_oe, .core_data_in,
		.host_addr_data_bus_in, .host_addr_data_bus_out,
		.host_addr_data_bus_oe, .host_ctl_pins, .host_port_acknowledge,
		.serial_alt_mode, .serial_irq_edge_sel, .serial_data_in,
		.serial_data_out, .serial_core_tx, .serial_core_rx,
		.serial_clk_fs_in, .alt_flag_output_core, .alt_flag_input,
		.alt_serial_irq_pins);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [23:0] exp, got);
		samples_checked++;
		if (exp !== got) begin
			err_count++;
			$display("[FAIL] %s expected %h got %h", nm, exp, got);
		end
	endtask
	task automatic complete_run;
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic do_reset(input logic [2:0] m);
		mode_val = m;
		resetn = 1'b0;
		step(8);
		chk("strap_oe", 24'h0, strap_flag_oe);
		resetn = 1'b1;
		step(3);
	endtask
	initial begin
		err_count = 0;
		samples_checked = 0;
		{core_flag_out, core_flag_dir} = 6'h28;
		{sh_ext, shared_flag_out, shared_flag_dir} = 12'h000;
		interrupt_mask_reg = 4'hf;
		core_bus = {14'h2a5d, 24'hc3b1e7, 24'hffffff, 8'h9d, 1'b0};
		host_core = {16'h5aa5, 16'hffff, 1'b1};
		host_ctl_pins = 4'ha;
		host_addr_data_bus_in = 16'h1234;
		external_data_bus_in = 24'h00abcd;
		{serial_alt_mode, serial_data_in, serial_core_tx} = 3'h2;
		alt_flag_output_core = 1'b1;
		{serial_irq_edge_sel, serial_clk_fs_in} = 4'h3;
		// Host mode: strap pattern 100
		do_reset(3'h4);
		chk("mode", HOST_MODE, mem_mode);
		chk("strap_value", 24'h4, strap_value);
		chk("host_in", {16'h1234, 4'ha}, host_in);
		chk("ack", 24'h1, host_port_acknowledge);
		chk("hb_out", 24'h5aa5, host_addr_data_bus_out);
		chk("hb_oe", 24'hffff, host_addr_data_bus_oe);
		chk("addr", 24'h1, external_address_bus);
		chk("data_oe", 24'hffff00, external_data_bus_oe);
		chk("h_data_out", 24'hc3b100, external_data_bus_out);
		chk("h_data_in", 24'h00ab00, core_data_in);
		// Glue logic decodes peripherals from the low address bit
		core_bus.addr = 14'h2a5c;
		step(2);
		chk("addr_lsb", 24'h0, external_address_bus);
		core_bus.addr = 14'h2a5d;
		core_flag_dir = 3'h7;
		step(3);
		chk("flag_oe", 24'h7, strap_flag_oe);
		chk("flag_out", 24'h5, strap_flag_out);
		chk("flag_in", 24'h5, core_flag_in);
		// Released strap pin now reads mode C low
		core_flag_dir = 3'h0;
		step(3);
		chk("flag_in", 24'h3, core_flag_in);
		chk("mode_held", HOST_MODE, mem_mode);
		// Full-memory mode: strap pattern 011
		do_reset(3'h3);
		chk("mode", FULL_MEMORY, mem_mode);
		chk("addr", 24'h2a5d, external_address_bus);
		chk("data_out", 24'hc3b1e7, external_data_bus_out);
		chk("data_in", 24'h00abcd, core_data_in);
		chk("host_in", 24'h0, host_in);
		chk("hb_oe_full", 24'h0, host_addr_data_bus_oe);
		chk("ack_full", 24'h0, host_port_acknowledge);
		core_bus.byte_access = 1'b1;
		step(2);
		chk("byte_hi", 24'h9db1e7, external_data_bus_out);
		// Shared interrupt/flag pins
		sh_ext = 4'h5;
		step(2);
		chk("irq", 24'h5, shared_irq_req);
		chk("sh_flag_in", 24'h5, shared_flag_in);
		interrupt_mask_reg = 4'h3;
		step(2);
		chk("irq_mask", 24'h1, shared_irq_req);
		{shared_flag_dir, shared_flag_out, interrupt_mask_reg} = 12'h88f;
		step(3);
		chk("irq_self", 24'hd, shared_irq_req);
		chk("sh_oe", 24'h8, shared_pin_oe);
		chk("sh_out", 24'h8, shared_pin_out);
		// Second serial port alternate role, level then edge sense
		{serial_alt_mode, serial_clk_fs_in} = 3'h6;
		step(2);
		chk("alt_irq", 24'h1, alt_serial_irq_pins);
		chk("alt_fi", 24'h1, alt_flag_input);
		chk("alt_fo", 24'h1, serial_data_out);
		chk("alt_rx", 24'h0, serial_core_rx);
		{serial_irq_edge_sel, serial_clk_fs_in} = 4'hb;
		step(2);
		serial_clk_fs_in = 2'h1;
		seen = 1'b0;
		repeat (4) begin
			step(1);
			seen |= alt_serial_irq_pins[1];
		end
		chk("edge_seen", 24'h1, seen);
		step(2);
		chk("edge_once", 24'h0, alt_serial_irq_pins[1]);
		// Role switched back while running
		serial_alt_mode = 1'b0;
		step(2);
		chk("sport_tx", 24'h0, serial_data_out);
		chk("sport_rx", 24'h1, serial_core_rx);
		complete_run();
	end
endmodule
`default_nettype wire
